/* amp_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef AMP_REGS_SVH
`define AMP_REGS_SVH
`define AMP_WORD_W 12
`define AMP_ADDR_CFG 4'h0
`define AMP_ADDR_OFS 4'h2
`define AMP_ADDR_FSR 4'h3
`define AMP_ADDR_SKEW 4'h7
`define AMP_ADDR_TAD 4'hc
`define AMP_CFG_PHASE 14
`define AMP_CFG_DES 7
`define AMP_CFG_QSEL 6
`define AMP_CFG_DUAL 5
`define AMP_OFS_SIGN 12
`define AMP_CFG_RST 16'h0000
`define AMP_OFS_RST 16'h0000
`define AMP_FSR_MID 15'h4000
`define AMP_FSR_MIN 15'h0000
`define AMP_SKEW_RST 7'h40
`define AMP_TAD_RST 3'h0
`define AMP_RSV_OK 2'h2
`define AMP_HDR_BITS 5'h08
`define AMP_FRAME_BITS 5'h18
`endif

/* amp_pkg.sv */
// types shared by the converter control block
package amp_pkg;
`include "amp_regs.svh"
	typedef enum logic [2:0] {
		SP_IDLE = 3'h1,
		SP_SHIFT = 3'h2,
		SP_DONE = 3'h4
	} amp_sp_state_e;

	typedef struct packed {
		logic [`AMP_WORD_W-1:0] qd;
		logic [`AMP_WORD_W-1:0] id;
		logic [`AMP_WORD_W-1:0] q;
		logic [`AMP_WORD_W-1:0] i;
	} amp_bus_s;

	typedef struct packed {
		logic extended_control_mode;
		logic des;
		logic qsel;
		logic dual;
		logic ph90;
	} amp_mode_s;
endpackage

/* amp_core.sv */
// converter mode control, serial register port and ddr output framing
// Operation
// - register mode offers a 15-bit full-scale range code via registers.
// - pin mode range pin picks mid or minimum register range code.
// - register mode offers 12-bit offset magnitude plus sign.
// - two-edge mode: one channel samples on rising, other on falling.
// - pin-controlled two-edge mode samples the I input only.
// - config bit 7 enables two-edge sampling in register mode.
// - config bit 6 routes Q input to both channels unless bit 5 is set, else I.
// - config bit 5 selects both inputs driven, each to own channel.
// - demux two-edge words ordered delayed Q, delayed I, Q, I.
// - non-demux two-edge edge carries Q earlier and I later.
// - skew register at 7h takes 0 to 127, defaults 64.
// - two-edge mode runs continuous background I/Q phase trim.
// - register mode allows programmable internal sampling clock delay.
// - sampling clock delay also delays forwarded clock and data.
// - output is ddr; forwarded clock half the word rate.
// - 0 degree phase: data changes on every forwarded clock edge.
// - 90 degree phase: forwarded clock toggles mid data cell.
// - phase from phase pin in pin mode, config bit 14 otherwise.
// - serial frame carries 4-bit address, msb first, 16 addresses.
// - serial frame carries 16-bit data written or read back.
`timescale 1ns/1ps
`include "amp_regs.svh"
module amp_core
	import amp_pkg::*;
#(
	parameter int DLY_DEPTH = 8,
	parameter int BG_W = 6
)
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// mode pins
	input wire logic ecm_n_i,
	input wire logic des_pin_i,
	input wire logic output_phase_pin_i,
	input wire logic range_select_pin_i,
	input wire logic demux_pin_i,
	// serial control port
	input wire logic scs_n_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// sampled inputs
	input wire logic [`AMP_WORD_W-1:0] i_in_i,
	input wire logic [`AMP_WORD_W-1:0] q_in_i,
	// ddr output
	output amp_bus_s out_word_o,
	output logic forwarded_output_clock_o,
	// trim settings
	output logic [14:0] fsr_code_o,
	output logic [11:0] offset_mag_o,
	output logic offset_neg_o,
	output logic [6:0] skew_code_o,
	output logic [2:0] clk_delay_o,
	output logic [BG_W-1:0] bg_trim_o
);

	if (DLY_DEPTH < 7)
	begin : g_chk_dly
		$error("DLY_DEPTH must cover delay code 7");
	end
	if (BG_W < 2)
	begin : g_chk_bg
		$error("BG_W must be at least 2");
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	function automatic logic [15:0] reg_read(input logic [3:0] a, input logic [15:0] cfg,
		input logic [15:0] ofs, input logic [14:0] range_select_pin, input logic [6:0] skw, input logic [2:0] tad);
		logic [15:0] r;
		r = 16'h0000;
		case (a)
			`AMP_ADDR_CFG: r = cfg;
			`AMP_ADDR_OFS: r = ofs;
			`AMP_ADDR_FSR: r = {1'b0, range_select_pin};
			`AMP_ADDR_SKEW: r = {9'h000, skw};
			`AMP_ADDR_TAD: r = {13'h0000, tad};
			default: r = 16'h0000;
		endcase
		return r;
	endfunction

	// pin synchronisers: ecm_n, des, phase, range, demux, cs_n, sclk, sdi
	logic [7:0] s1_q, s2_q;
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			s1_q <= 8'h21;
			s2_q <= 8'h21;
		end
		else
		begin
			s1_q <= {sdi_i, sclk_i, scs_n_i, demux_pin_i, range_select_pin_i,
				output_phase_pin_i, des_pin_i, ecm_n_i};
			s2_q <= s1_q;
		end
	end
	logic ecm_s, des_pin_s, ph_pin_s, rng_pin_s, demux_s, cs_n_s, sclk_s, sdi_s;
	assign ecm_s = !s2_q[0];
	assign des_pin_s = s2_q[1];
	assign ph_pin_s = s2_q[2];
	assign rng_pin_s = s2_q[3];
	assign demux_s = s2_q[4];
	assign cs_n_s = s2_q[5];
	assign sclk_s = s2_q[6];
	assign sdi_s = s2_q[7];

	// serial port
	amp_sp_state_e sp_q, sp_d;
	logic sclk_prev_q, sclk_prev_d;
	logic [4:0] cnt_q, cnt_d;
	logic [23:0] sh_q, sh_d;
	logic [15:0] rd_q, rd_d;
	logic sdo_q, sdo_d, oe_q, oe_d;
	logic wr_go;
	logic [3:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] cfg_q, cfg_d, ofs_q, ofs_d;
	logic [14:0] fsr_q, fsr_d;
	logic [6:0] skew_q, skew_d;
	logic [2:0] tad_q, tad_d;
	logic sclk_rise, sclk_fall;
	assign sclk_rise = sclk_s && !sclk_prev_q;
	assign sclk_fall = !sclk_s && sclk_prev_q;
	assign wr_addr = sh_q[20:17];
	assign wr_data = sh_q[15:0];

	always_comb
	begin
		sp_d = sp_q;
		sclk_prev_d = sclk_s;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rd_d = rd_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		wr_go = 1'b0;
		case (sp_q)
			SP_IDLE:
			begin
				cnt_d = 5'h00;
				oe_d = 1'b0;
				if (!cs_n_s)
					sp_d = SP_SHIFT;
			end
			SP_SHIFT:
			begin
				if (cs_n_s)
				begin
					sp_d = SP_IDLE;
					oe_d = 1'b0;
				end
				else if (sclk_rise)
				begin
					sh_d = {sh_q[22:0], sdi_s};
					cnt_d = cnt_q + 5'h01;
					if (cnt_d == `AMP_HDR_BITS)
						rd_d = reg_read(sh_d[4:1], cfg_q, ofs_q, fsr_q, skew_q, tad_q);
					if (cnt_d == `AMP_FRAME_BITS)
					begin
						sp_d = SP_DONE;
						wr_go = !sh_d[23] && (sh_d[22:21] == `AMP_RSV_OK);
					end
				end
				else if (sclk_fall && cnt_q >= `AMP_HDR_BITS && sh_q[cnt_q - 5'h01])
				begin
					sdo_d = rd_q[15];
					rd_d = {rd_q[14:0], 1'b0};
					oe_d = 1'b1;
				end
			end
			SP_DONE:
			begin
				if (sclk_fall)
					oe_d = 1'b0;
				if (cs_n_s)
				begin
					sp_d = SP_IDLE;
					oe_d = 1'b0;
				end
			end
			default: sp_d = SP_IDLE;
		endcase
	end

	// read flag is the first frame bit, so it always sits at sh bit (cnt-1)
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			sp_q <= SP_IDLE;
			sclk_prev_q <= 1'b0;
			cnt_q <= 5'h00;
			sh_q <= 24'h000000;
			rd_q <= 16'h0000;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end
		else
		begin
			sp_q <= sp_d;
			sclk_prev_q <= sclk_prev_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
		end
	end

	// register file, written one cycle after the last frame bit
	logic wr_q;
	always_comb
	begin
		cfg_d = cfg_q;
		ofs_d = ofs_q;
		fsr_d = fsr_q;
		skew_d = skew_q;
		tad_d = tad_q;
		if (wr_q)
		begin
			case (wr_addr)
				`AMP_ADDR_CFG: cfg_d = wr_data;
				`AMP_ADDR_OFS: ofs_d = {3'h0, wr_data[12:0]};
				`AMP_ADDR_FSR: fsr_d = wr_data[14:0];
				`AMP_ADDR_SKEW: skew_d = wr_data[6:0];
				`AMP_ADDR_TAD: tad_d = wr_data[2:0];
				default: cfg_d = cfg_q;
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			wr_q <= 1'b0;
			cfg_q <= `AMP_CFG_RST;
			ofs_q <= `AMP_OFS_RST;
			fsr_q <= `AMP_FSR_MID;
			skew_q <= `AMP_SKEW_RST;
			tad_q <= `AMP_TAD_RST;
		end
		else
		begin
			wr_q <= wr_go;
			cfg_q <= cfg_d;
			ofs_q <= ofs_d;
			fsr_q <= fsr_d;
			skew_q <= skew_d;
			tad_q <= tad_d;
		end
	end

	// effective mode; pin mode takes the two-edge input from I only
	amp_mode_s mode_q, mode_d;
	always_comb
	begin
		mode_d.extended_control_mode = ecm_s;
		mode_d.des = ecm_s ? cfg_q[`AMP_CFG_DES] : des_pin_s;
		mode_d.qsel = ecm_s && cfg_q[`AMP_CFG_QSEL];
		mode_d.dual = ecm_s && cfg_q[`AMP_CFG_DUAL];
		mode_d.ph90 = ecm_s ? cfg_q[`AMP_CFG_PHASE] : ph_pin_s;
	end

	// sampling clock model: one edge per cycle, delayed as programmed
	logic ph_q;
	logic [DLY_DEPTH-1:0] hist_q;
	logic dph_prev_q, dph, rise, fall;
	logic [`AMP_WORD_W-1:0] ch_i_q, ch_i_d, ch_q_q, ch_q_d;
	logic pair_v_q, fall_v_q;
	logic [BG_W-1:0] bg_q, bg_d;
	// delay only available in register mode
	assign dph = (tad_q == 3'h0 || !mode_q.extended_control_mode) ? ph_q : hist_q[tad_q - 3'h1];
	assign rise = dph && !dph_prev_q;
	assign fall = !dph && dph_prev_q;

	always_comb
	begin
		ch_i_d = ch_i_q;
		ch_q_d = ch_q_q;
		bg_d = bg_q;
		if (rise)
		begin
			ch_i_d = (mode_q.des && mode_q.qsel && !mode_q.dual) ? q_in_i : i_in_i;
			if (!mode_q.des)
				ch_q_d = q_in_i;
		end
		if (fall && mode_q.des)
			ch_q_d = (mode_q.dual || mode_q.qsel) ? q_in_i : i_in_i;
		if (pair_v_q && mode_q.des)
		begin
			if (ch_i_q > ch_q_q && bg_q != {BG_W{1'b1}})
				bg_d = bg_q + 1'b1;
			else if (ch_i_q < ch_q_q && bg_q != {BG_W{1'b0}})
				bg_d = bg_q - 1'b1;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			mode_q <= '0;
			ph_q <= 1'b0;
			hist_q <= '0;
			dph_prev_q <= 1'b0;
			ch_i_q <= '0;
			ch_q_q <= '0;
			pair_v_q <= 1'b0;
			fall_v_q <= 1'b0;
			bg_q <= {1'b1, {(BG_W-1){1'b0}}};
		end
		else
		begin
			mode_q <= mode_d;
			ph_q <= !ph_q;
			hist_q <= {hist_q[DLY_DEPTH-2:0], ph_q};
			dph_prev_q <= dph;
			ch_i_q <= ch_i_d;
			ch_q_q <= ch_q_d;
			pair_v_q <= rise;
			fall_v_q <= fall;
			bg_q <= bg_d;
		end
	end

	// ddr output framing
	amp_bus_s word_q, word_d;
	logic [`AMP_WORD_W-1:0] hold_q_q, hold_q_d, hold_i_q, hold_i_d;
	logic half_q, half_d, fclk_q, fclk_d, launch, mid;
	always_comb
	begin
		word_d = word_q;
		hold_q_d = hold_q_q;
		hold_i_d = hold_i_q;
		half_d = half_q;
		launch = 1'b0;
		mid = 1'b0;
		if (demux_s)
		begin
			if (pair_v_q)
			begin
				half_d = !half_q;
				if (half_q)
				begin
					launch = 1'b1;
					word_d = '{qd: hold_q_q, id: hold_i_q, q: ch_q_q, i: ch_i_q};
				end
				else
				begin
					mid = 1'b1;
					hold_q_d = ch_q_q;
					hold_i_d = ch_i_q;
				end
			end
		end
		else
		begin
			half_d = 1'b0;
			mid = fall_v_q;
			if (pair_v_q)
			begin
				launch = 1'b1;
				word_d = '{qd: '0, id: '0, q: ch_q_q, i: ch_i_q};
			end
		end
		fclk_d = fclk_q ^ (mode_q.ph90 ? mid : launch);
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			word_q <= '0;
			hold_q_q <= '0;
			hold_i_q <= '0;
			half_q <= 1'b0;
			fclk_q <= 1'b0;
			fsr_code_o <= `AMP_FSR_MID;
			offset_mag_o <= 12'h000;
			offset_neg_o <= 1'b0;
		end
		else
		begin
			word_q <= word_d;
			hold_q_q <= hold_q_d;
			hold_i_q <= hold_i_d;
			half_q <= half_d;
			fclk_q <= fclk_d;
			fsr_code_o <= ecm_s ? fsr_q : (rng_pin_s ? `AMP_FSR_MID : `AMP_FSR_MIN);
			offset_mag_o <= ecm_s ? ofs_q[11:0] : 12'h000;
			offset_neg_o <= ecm_s && ofs_q[`AMP_OFS_SIGN];
		end
	end

	assign out_word_o = word_q;
	assign forwarded_output_clock_o = fclk_q;
	assign sdo_o = sdo_q;
	assign sdo_oe_o = oe_q;
	assign skew_code_o = skew_q;
	assign clk_delay_o = tad_q;
	assign bg_trim_o = bg_q;

	sequence s_des_fall;
		mode_q.des && fall;
	endsequence

	a_fsr_pin_lvl: assert property (!ecm_s ##1 !ecm_s
		|=> fsr_code_o == ($past(rng_pin_s) ? `AMP_FSR_MID : `AMP_FSR_MIN))
		else $error("pin range level wrong");
	a_des_q_fall: assert property (mode_q.des && rise && !fall |=> ch_q_q == $past(ch_q_q))
		else $error("q channel moved on rising edge in two-edge mode");
	a_pin_i_only: assert property (s_des_fall ##0 !mode_q.extended_control_mode |=> ch_q_q == $past(i_in_i))
		else $error("pin two-edge mode did not sample I input");
	a_qsel_route: assert property (mode_q.des && mode_q.qsel && !mode_q.dual && rise
		|=> ch_i_q == $past(q_in_i))
		else $error("Q select not routed to I channel");
	a_dual_route: assert property (s_des_fall ##0 mode_q.dual |=> ch_q_q == $past(q_in_i))
		else $error("dual driven mode did not use Q input");
	a_nondes_same: assert property (!mode_q.des && rise
		|=> ch_q_q == $past(q_in_i) && ch_i_q == $past(i_in_i))
		else $error("independent channels not sampled together");
	a_bg_hold: assert property (!mode_q.des |=> $stable(bg_q))
		else $error("background trim moved outside two-edge mode");
	a_phase0_edge: assert property (launch && !mode_q.ph90
		|=> forwarded_output_clock_o != $past(forwarded_output_clock_o))
		else $error("0 degree clock did not toggle with data");
	a_phase90_mid: assert property (launch && mode_q.ph90 && !mid
		|=> forwarded_output_clock_o == $past(forwarded_output_clock_o))
		else $error("90 degree clock toggled at data change");
	a_cfg_write: assert property (wr_q && wr_addr == `AMP_ADDR_CFG |=> cfg_q == $past(wr_data))
		else $error("config write lost");
endmodule

/* amp_capture.sv */
// capture-side model counting forwarded clock edges and the edges on which the word changes
`timescale 1ns/1ps
module amp_capture
	import amp_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// window control
	input wire logic clr_i,
	// ddr link
	input wire amp_bus_s word_i,
	input wire logic fclk_i,
	// counts
	output logic [15:0] edge_cnt_o,
	output logic [15:0] same_cnt_o
);
	amp_bus_s word_q;
	logic fclk_q;
	logic tgl;
	assign tgl = fclk_i ^ fclk_q;
	always_ff @(posedge clock_i)
	begin
		word_q <= word_i;
		fclk_q <= fclk_i;
		if (!rst_n_i || clr_i)
		begin
			edge_cnt_o <= 16'h0000;
			same_cnt_o <= 16'h0000;
		end
		else
		begin
			edge_cnt_o <= edge_cnt_o + {15'h0000, tgl};
			same_cnt_o <= same_cnt_o + {15'h0000, tgl && (word_i != word_q)};
		end
	end
endmodule

/* testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench
	import amp_pkg::*;
;
	localparam logic [11:0] IV = 12'h5a3;
	localparam logic [11:0] QV = 12'h1c6;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ecm_n = 1'b0, des_pin = 1'b0, ph_pin = 1'b0, rng_pin = 1'b0, demux = 1'b0;
	logic scs_n = 1'b1, sclk = 1'b0, sdi = 1'b0, ramp = 1'b0, clr = 1'b0;
	logic [11:0] i_in = IV, q_in = QV;
	logic sdo, sdo_oe, fclk, oneg;
	amp_bus_s word;
	logic [14:0] range_select_pin;
	logic [11:0] omag;
	logic [6:0] skew;
	logic [2:0] dly;
	logic [5:0] bg;
	logic [15:0] ec, sc, rdat;
	int error_cnt = 0, checks = 0, cyc = 0;
	logic [15:0] cfgs [5] = '{16'h0000, 16'h0040, 16'h0080, 16'h00c0, 16'h00a0};
	logic [47:0] exps [5] = '{{24'h0, QV, IV}, {24'h0, QV, IV}, {24'h0, IV, IV},
		{24'h0, QV, QV}, {24'h0, QV, IV}};

	always #50 clock_i = ~clock_i;

	amp_core u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ecm_n_i(ecm_n), .des_pin_i(des_pin),
		.output_phase_pin_i(ph_pin), .range_select_pin_i(rng_pin), .demux_pin_i(demux),
		.scs_n_i(scs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
		.i_in_i(i_in), .q_in_i(q_in), .out_word_o(word), .forwarded_output_clock_o(fclk),
		.fsr_code_o(range_select_pin), .offset_mag_o(omag), .offset_neg_o(oneg), .skew_code_o(skew),
		.clk_delay_o(dly), .bg_trim_o(bg));
	amp_capture u_cap (.clock_i(clock_i), .rst_n_i(rst_n_i), .clr_i(clr), .word_i(word),
		.fclk_i(fclk), .edge_cnt_o(ec), .same_cnt_o(sc));

	task automatic final_report();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// one 24-bit frame, sclk 4 cycles low then 4 high
	task automatic xfer(input logic [1:0] rsv, input logic rd, input logic [3:0] a,
		input logic [15:0] d);
		logic [23:0] f;
		f = {rd, rsv, a, 1'b0, d};
		@(posedge clock_i);
		scs_n <= 1'b0;
		repeat (4) @(posedge clock_i);
		for (int n = 23; n >= 0; n--)
		begin
			sdi <= f[n];
			repeat (4) @(posedge clock_i);
			sclk <= 1'b1;
			repeat (4) @(posedge clock_i);
			if (n < 16)
				rdat[n] = sdo_oe ? sdo : 1'bx;
			sclk <= 1'b0;
		end
		repeat (6) @(posedge clock_i);
		scs_n <= 1'b1;
		sdi <= ~sdi;
		repeat (4) @(posedge clock_i);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		xfer(2'b10, 1'b0, a, d);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		xfer(2'b10, 1'b1, a, 16'h0000);
		chk(rdat, e);
	endtask

	// counts forwarded clock edges over 40 cycles
	task automatic win(input logic [15:0] ee, input logic [15:0] es);
		@(posedge clock_i);
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
		repeat (41) @(posedge clock_i);
		chk({ec, sc}, {ee, es});
	endtask

	always @(posedge clock_i)
		if (ramp)
		begin
			i_in <= i_in + 12'h001;
			q_in <= q_in - 12'h003;
		end

	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("unexpected at %0t: run too long", $time);
			final_report();
		end
	end

	initial
	begin
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk({range_select_pin, skew, dly, oneg, omag, bg}, {15'h4000, 7'h40, 3'h0, 13'h0, 6'h20});
		rdchk(4'h0, 16'h0000);
		rdchk(4'h7, 16'h0040);
		rdchk(4'h3, 16'h4000);
		wr(4'h7, 16'h007f);
		rdchk(4'h7, 16'h007f);
		wr(4'h7, 16'h0000);
		xfer(2'b01, 1'b0, 4'h7, 16'h0055);
		chk(skew, 7'h00);
		wr(4'h3, 16'h7fff);
		wr(4'h0, 16'h8000);
		wr(4'h2, 16'h1fff);
		chk({range_select_pin, oneg, omag}, {15'h7fff, 13'h1fff});
		wr(4'h5, 16'habcd);
		rdchk(4'h5, 16'h0000);
		chk(bg, 6'h20);
		// output word checked for each routing setting in cfgs
		for (int k = 0; k < 5; k++)
		begin
			wr(4'h0, cfgs[k]);
			repeat (20) @(posedge clock_i);
			chk(word, exps[k]);
		end
		repeat (100) @(posedge clock_i);
		chk(bg, 6'h3f);
		demux <= 1'b1;
		wr(4'h0, 16'h0080);
		repeat (20) @(posedge clock_i);
		chk(word, {IV, IV, IV, IV});
		ramp <= 1'b1;
		// I input ramps one per cycle, so successive samples differ by one
		repeat (12) @(posedge clock_i);
		chk({word.id - word.qd, word.q - word.id, word.i - word.q}, 36'h001001001);
		win(16'h000a, 16'h000a);
		demux <= 1'b0;
		repeat (20) @(posedge clock_i);
		win(16'h0014, 16'h0014);
		wr(4'h0, 16'h4080);
		win(16'h0014, 16'h0000);
		wr(4'h0, 16'h00c0);
		wr(4'hc, 16'h0003);
		chk(dly, 3'h3);
		win(16'h0014, 16'h0014);
		ramp <= 1'b0;
		@(posedge clock_i);
		i_in <= IV;
		q_in <= QV;
		ecm_n <= 1'b1;
		des_pin <= 1'b1;
		repeat (20) @(posedge clock_i);
		chk({word, range_select_pin, omag}, {24'h0, IV, IV, 15'h0000, 12'h000});
		rng_pin <= 1'b1;
		repeat (10) @(posedge clock_i);
		chk(range_select_pin, 15'h4000);
		ph_pin <= 1'b1;
		ramp <= 1'b1;
		repeat (10) @(posedge clock_i);
		win(16'h0014, 16'h0000);
		final_report();
	end
endmodule
